// ==== logic/pin_cell.sv ====
package pin_mux_pkg;

    localparam int NUM_PINS     = 32;
    localparam int NUM_IRQ      = 15;
    localparam int IRQ_BASE_PIN = 3;
    localparam int STRAP_W      = 3;

    localparam int PIN_CNT_A = 1;
    localparam int PIN_CNT_B = 2;
    localparam int PIN_TSYN  = 3;
    localparam int PIN_TCLK  = 4;
    localparam int PIN_TDAT  = 5;
    localparam int PIN_RSYN  = 6;
    localparam int PIN_RCLK  = 7;
    localparam int PIN_RDAT  = 8;

    localparam logic [STRAP_W-1:0] ID_RESET = 3'h0;

    typedef enum logic [1:0] {
        FN_GPIO,
        FN_PERIPH,
        FN_IRQ
    } fn_t;

    typedef enum logic [2:0] {
        GM_PLAIN,
        GM_DED_IN0,
        GM_DED_IN1,
        GM_DED_OUT0,
        GM_DED_OUT1
    } gmode_t;

    typedef enum logic [3:0] {
        PER_NONE,
        PER_CNT_A,
        PER_CNT_B,
        PER_TSYN,
        PER_TCLK,
        PER_TDAT,
        PER_RSYN,
        PER_RCLK,
        PER_RDAT
    } per_t;

    function automatic per_t periph_of(input int pin);
        case (pin)
            PIN_CNT_A: periph_of = PER_CNT_A;
            PIN_CNT_B: periph_of = PER_CNT_B;
            PIN_TSYN:  periph_of = PER_TSYN;
            PIN_TCLK:  periph_of = PER_TCLK;
            PIN_TDAT:  periph_of = PER_TDAT;
            PIN_RSYN:  periph_of = PER_RSYN;
            PIN_RCLK:  periph_of = PER_RCLK;
            PIN_RDAT:  periph_of = PER_RDAT;
            default:   periph_of = PER_NONE;
        endcase
    endfunction

endpackage

module pin_cell (
    // selection
    input  wire pin_mux_pkg::fn_t    fn,
    input  wire pin_mux_pkg::gmode_t gmode,
    // core side
    input  wire logic                gpio_out,
    input  wire logic                gpio_dir,
    input  wire logic                ded_out0,
    input  wire logic                ded_out1,
    input  wire logic                per_out,
    input  wire logic                per_drive,
    output logic                     gpio_rd,
    output logic                     ded_rd0,
    output logic                     ded_rd1,
    output logic                     per_rd,
    output logic                     irq_rd,
    // pad side
    input  wire logic                pad_in,
    output logic                     drive,
    output logic                     out
);
    // one owner per pin; every unselected reader sees a quiet low
    always_comb begin
        drive   = 1'b0;
        out     = 1'b0;
        gpio_rd = 1'b0;
        ded_rd0 = 1'b0;
        ded_rd1 = 1'b0;
        per_rd  = 1'b0;
        irq_rd  = 1'b0;
        case (fn)
            pin_mux_pkg::FN_GPIO: begin
                case (gmode)
                    pin_mux_pkg::GM_PLAIN: begin
                        drive   = gpio_dir;
                        out     = gpio_out;
                        gpio_rd = pad_in;
                    end
                    pin_mux_pkg::GM_DED_IN0:  ded_rd0 = pad_in;
                    pin_mux_pkg::GM_DED_IN1:  ded_rd1 = pad_in;
                    pin_mux_pkg::GM_DED_OUT0: begin
                        drive = 1'b1;
                        out   = ded_out0;
                    end
                    pin_mux_pkg::GM_DED_OUT1: begin
                        drive = 1'b1;
                        out   = ded_out1;
                    end
                    default: drive = 1'b0;
                endcase
            end
            pin_mux_pkg::FN_PERIPH: begin
                drive  = per_drive;
                out    = per_out;
                // a driven function pin does not echo back as input
                per_rd = per_drive ? 1'b0 : pad_in;
            end
            pin_mux_pkg::FN_IRQ: irq_rd = pad_in;
            default: drive = 1'b0;
        endcase
    end
endmodule

// ==== logic/shared_pin_function_mux.sv ====
// Notes on behaviour
// - each pin serves at most one selected function
// - 32 gpio pins, plain, dedicated in or out
// - identity straps latched on power-on reset rise
// - counter pins individually input or output
// - fifteen interrupt lines forwarded to controller
// - transmit data pin drives serial data line D
// - receive sync pin may carry data line B
// - receive clock pin bidirectional, may carry C
// - receive data pin carries data line A
module shared_pin_function_mux #(
    parameter int NUM_PINS = pin_mux_pkg::NUM_PINS,
    parameter int NUM_IRQ  = pin_mux_pkg::NUM_IRQ
) (
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   sys_rst,
    // pin configuration
    input  wire pin_mux_pkg::fn_t       pin_fn    [NUM_PINS],
    input  wire pin_mux_pkg::gmode_t    gpio_mode [NUM_PINS],
    input  wire logic                   counter_a_drive,
    input  wire logic                   counter_b_drive,
    input  wire logic                   tsyn_drive,
    input  wire logic                   rsyn_as_data_b,
    input  wire logic                   rclk_as_data_c,
    input  wire logic                   rclk_drive,
    // gpio unit
    input  wire logic [NUM_PINS-1:0]    gpio_out,
    input  wire logic [NUM_PINS-1:0]    gpio_dir,
    input  wire logic [NUM_PINS-1:0]    ded_out0,
    input  wire logic [NUM_PINS-1:0]    ded_out1,
    output logic      [NUM_PINS-1:0]    gpio_rd,
    output logic      [NUM_PINS-1:0]    ded_rd0,
    output logic      [NUM_PINS-1:0]    ded_rd1,
    // counters
    input  wire logic                   counter_a_out,
    input  wire logic                   counter_b_out,
    output logic                        counter_a_in,
    output logic                        counter_b_in,
    // serial port
    input  wire logic                   tx_frame_sync_out,
    input  wire logic                   data_d_out,
    input  wire logic                   rx_clock_out,
    input  wire logic                   data_c_out,
    output logic                        tx_frame_sync_in,
    output logic                        tx_clock_in,
    output logic                        rx_frame_sync_in,
    output logic                        rx_clock_in,
    output logic                        data_a_in,
    output logic                        data_b_in,
    output logic                        data_c_in,
    // interrupt controller
    output logic      [NUM_IRQ-1:0]     irq_req,
    // identity straps
    input  wire logic                   power_on_reset_in,
    input  wire logic                   identity_strap_bit0,
    input  wire logic                   identity_strap_bit1,
    input  wire logic                   identity_strap_bit2,
    output logic [pin_mux_pkg::STRAP_W-1:0] identity_id,
    // pads
    input  wire logic [NUM_PINS-1:0]    pad_in,
    output logic      [NUM_PINS-1:0]    pad_out,
    output logic      [NUM_PINS-1:0]    pad_oe_n
);
    typedef struct packed {
        logic [NUM_PINS-1:0]             pad_out;
        logic [NUM_PINS-1:0]             pad_oe_n;
        logic [NUM_PINS-1:0]             gpio_rd;
        logic [NUM_PINS-1:0]             ded_rd0;
        logic [NUM_PINS-1:0]             ded_rd1;
        logic [NUM_IRQ-1:0]              irq_req;
        logic                            counter_a_in;
        logic                            counter_b_in;
        logic                            tx_frame_sync_in;
        logic                            tx_clock_in;
        logic                            rx_frame_sync_in;
        logic                            rx_clock_in;
        logic                            data_a_in;
        logic                            data_b_in;
        logic                            data_c_in;
        logic [pin_mux_pkg::STRAP_W-1:0] identity_id;
        logic                            por_q;
    } state_t;

    state_t              st_q;
    state_t              st_d;
    logic [NUM_PINS-1:0] per_out;
    logic [NUM_PINS-1:0] per_drive;
    logic [NUM_PINS-1:0] per_rd;
    logic [NUM_PINS-1:0] irq_rd;
    logic [NUM_PINS-1:0] drive;
    logic [NUM_PINS-1:0] out_w;
    logic [NUM_PINS-1:0] gpio_w;
    logic [NUM_PINS-1:0] ded0_w;
    logic [NUM_PINS-1:0] ded1_w;
    logic [pin_mux_pkg::STRAP_W-1:0] strap;

    assign strap = {identity_strap_bit2, identity_strap_bit1,
                    identity_strap_bit0};

    // what each dedicated function wants on its own pin
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            per_out[i]   = 1'b0;
            per_drive[i] = 1'b0;
            case (pin_mux_pkg::periph_of(i))
                pin_mux_pkg::PER_CNT_A: begin
                    per_drive[i] = counter_a_drive;
                    per_out[i]   = counter_a_out;
                end
                pin_mux_pkg::PER_CNT_B: begin
                    per_drive[i] = counter_b_drive;
                    per_out[i]   = counter_b_out;
                end
                pin_mux_pkg::PER_TSYN: begin
                    per_drive[i] = tsyn_drive;
                    per_out[i]   = tx_frame_sync_out;
                end
                pin_mux_pkg::PER_TDAT: begin
                    per_drive[i] = 1'b1;
                    per_out[i]   = data_d_out;
                end
                pin_mux_pkg::PER_RCLK: begin
                    per_drive[i] = rclk_drive;
                    per_out[i]   = rclk_as_data_c ? data_c_out
                                                  : rx_clock_out;
                end
                // transmit clock, receive sync and data only listen
                default: per_drive[i] = 1'b0;
            endcase
        end
    end

    generate
        for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
            pin_cell u_cell (
                .fn        (pin_fn[g]),
                .gmode     (gpio_mode[g]),
                .gpio_out  (gpio_out[g]),
                .gpio_dir  (gpio_dir[g]),
                .ded_out0  (ded_out0[g]),
                .ded_out1  (ded_out1[g]),
                .per_out   (per_out[g]),
                .per_drive (per_drive[g]),
                .gpio_rd   (gpio_w[g]),
                .ded_rd0   (ded0_w[g]),
                .ded_rd1   (ded1_w[g]),
                .per_rd    (per_rd[g]),
                .irq_rd    (irq_rd[g]),
                .pad_in    (pad_in[g]),
                .drive     (drive[g]),
                .out       (out_w[g])
            );
        end
    endgenerate

    always_comb begin
        st_d          = st_q;
        st_d.pad_out  = out_w;
        st_d.pad_oe_n = ~drive;
        st_d.gpio_rd  = gpio_w;
        st_d.ded_rd0  = ded0_w;
        st_d.ded_rd1  = ded1_w;
        st_d.irq_req  = irq_rd[pin_mux_pkg::IRQ_BASE_PIN +: NUM_IRQ];
        st_d.counter_a_in     = per_rd[pin_mux_pkg::PIN_CNT_A];
        st_d.counter_b_in     = per_rd[pin_mux_pkg::PIN_CNT_B];
        st_d.tx_frame_sync_in = per_rd[pin_mux_pkg::PIN_TSYN];
        st_d.tx_clock_in      = per_rd[pin_mux_pkg::PIN_TCLK];
        st_d.data_a_in        = per_rd[pin_mux_pkg::PIN_RDAT];
        // the alternate data use of a pin mutes its sync or clock role
        st_d.rx_frame_sync_in = rsyn_as_data_b ? 1'b0
                              : per_rd[pin_mux_pkg::PIN_RSYN];
        st_d.data_b_in        = rsyn_as_data_b
                              & per_rd[pin_mux_pkg::PIN_RSYN];
        st_d.rx_clock_in      = rclk_as_data_c ? 1'b0
                              : per_rd[pin_mux_pkg::PIN_RCLK];
        st_d.data_c_in        = rclk_as_data_c
                              & per_rd[pin_mux_pkg::PIN_RCLK];
        // straps are caught on the same clock that first sees the release
        st_d.por_q = power_on_reset_in;
        if (power_on_reset_in && !st_q.por_q) begin
            st_d.identity_id = strap;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q             <= '0;
            st_q.pad_oe_n    <= '1;
            st_q.identity_id <= pin_mux_pkg::ID_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign pad_out          = st_q.pad_out;
    assign pad_oe_n         = st_q.pad_oe_n;
    assign gpio_rd          = st_q.gpio_rd;
    assign ded_rd0          = st_q.ded_rd0;
    assign ded_rd1          = st_q.ded_rd1;
    assign irq_req          = st_q.irq_req;
    assign counter_a_in     = st_q.counter_a_in;
    assign counter_b_in     = st_q.counter_b_in;
    assign tx_frame_sync_in = st_q.tx_frame_sync_in;
    assign tx_clock_in      = st_q.tx_clock_in;
    assign rx_frame_sync_in = st_q.rx_frame_sync_in;
    assign rx_clock_in      = st_q.rx_clock_in;
    assign data_a_in        = st_q.data_a_in;
    assign data_b_in        = st_q.data_b_in;
    assign data_c_in        = st_q.data_c_in;
    assign identity_id      = st_q.identity_id;

    a_pin_owner: assert property (@(posedge mclk) disable iff (sys_rst)
        pin_fn[pin_mux_pkg::PIN_TSYN] == pin_mux_pkg::FN_IRQ
        |=> pad_oe_n[pin_mux_pkg::PIN_TSYN] && !tx_frame_sync_in
            && !gpio_rd[pin_mux_pkg::PIN_TSYN])
        else $error("irq pin also feeds another function");

    // a sampled reset means the next edge still shows reset values
    a_gpio_drive: assert property (@(posedge mclk) disable iff (sys_rst)
        !sys_rst && pin_fn[0] == pin_mux_pkg::FN_GPIO
        && gpio_mode[0] == pin_mux_pkg::GM_PLAIN && gpio_dir[0]
        |=> !pad_oe_n[0] && pad_out[0] == $past(gpio_out[0]))
        else $error("plain gpio output not on pad");

    a_ded_in: assert property (@(posedge mclk) disable iff (sys_rst)
        !sys_rst && pin_fn[9] == pin_mux_pkg::FN_GPIO
        && gpio_mode[9] == pin_mux_pkg::GM_DED_IN1
        |=> ded_rd1[9] == $past(pad_in[9]) && !ded_rd0[9] && pad_oe_n[9])
        else $error("dedicated input not routed");

    a_strap_take: assert property (@(posedge mclk) disable iff (sys_rst)
        !power_on_reset_in ##1 power_on_reset_in
        |=> identity_id == $past(strap, 1))
        else $error("identity not caught at reset rise");

    a_strap_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        power_on_reset_in [*3] |=> $stable(identity_id))
        else $error("identity changed without reset rise");

    a_counter_dir: assert property (@(posedge mclk) disable iff (sys_rst)
        !sys_rst && pin_fn[pin_mux_pkg::PIN_CNT_A] == pin_mux_pkg::FN_PERIPH
        |=> pad_oe_n[pin_mux_pkg::PIN_CNT_A] == !$past(counter_a_drive)
            && (counter_a_in == ($past(!counter_a_drive)
                && $past(pad_in[pin_mux_pkg::PIN_CNT_A]))))
        else $error("counter pin direction wrong");

    a_irq_fwd: assert property (@(posedge mclk) disable iff (sys_rst)
        !sys_rst && pin_fn[17] == pin_mux_pkg::FN_IRQ
        |=> irq_req[14] == $past(pad_in[17]))
        else $error("last irq line not forwarded");

    a_tx_data: assert property (@(posedge mclk) disable iff (sys_rst)
        !sys_rst && pin_fn[pin_mux_pkg::PIN_TDAT] == pin_mux_pkg::FN_PERIPH
        |=> !pad_oe_n[pin_mux_pkg::PIN_TDAT]
            && pad_out[pin_mux_pkg::PIN_TDAT] == $past(data_d_out))
        else $error("data line D not on transmit pin");

    a_sync_data_b: assert property (@(posedge mclk) disable iff (sys_rst)
        !sys_rst && pin_fn[pin_mux_pkg::PIN_RSYN] == pin_mux_pkg::FN_PERIPH
        && rsyn_as_data_b
        |=> data_b_in == $past(pad_in[pin_mux_pkg::PIN_RSYN])
            && !rx_frame_sync_in)
        else $error("data line B not taken from sync pin");

    a_rclk_data_c: assert property (@(posedge mclk) disable iff (sys_rst)
        !sys_rst && pin_fn[pin_mux_pkg::PIN_RCLK] == pin_mux_pkg::FN_PERIPH
        && rclk_as_data_c && !rclk_drive
        |=> data_c_in == $past(pad_in[pin_mux_pkg::PIN_RCLK])
            && !rx_clock_in && pad_oe_n[pin_mux_pkg::PIN_RCLK])
        else $error("data line C not taken from clock pin");

    a_tclk_input: assert property (@(posedge mclk) disable iff (sys_rst)
        !sys_rst && pin_fn[pin_mux_pkg::PIN_TCLK] == pin_mux_pkg::FN_PERIPH
        |=> pad_oe_n[pin_mux_pkg::PIN_TCLK]
            && tx_clock_in == $past(pad_in[pin_mux_pkg::PIN_TCLK]))
        else $error("transmit clock pin driven or not read");

    a_rx_data_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !sys_rst && pin_fn[pin_mux_pkg::PIN_RDAT] == pin_mux_pkg::FN_PERIPH
        |=> data_a_in == $past(pad_in[pin_mux_pkg::PIN_RDAT]))
        else $error("data line A not taken from receive pin");

    a_idle_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
        pin_fn[pin_mux_pkg::PIN_TCLK] != pin_mux_pkg::FN_PERIPH
        |=> !tx_clock_in)
        else $error("unassigned clock input not low");
endmodule

// ==== verification/board_model.sv ====
module board_model (
    // clock
    input  wire logic        mclk,
    // device side of the pads
    input  wire logic [31:0] pad_out,
    input  wire logic [31:0] pad_oe_n,
    // board drivers
    input  wire logic [31:0] ext_en,
    input  wire logic [31:0] ext_val,
    // wire level seen by the device
    output logic      [31:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // a floating pad churns every cycle, so a stale value never reads back
    logic [31:0] churn_q = 32'h55555555;

    always @(posedge mclk) begin
        churn_q <= ~churn_q;
    end

    // the board only drives where enabled and the device has let go;
    // the transmit clock pin is supplied from here only when ext_en enables it
    assign pad_in = (~pad_oe_n & pad_out)
                  | (pad_oe_n & ext_en & ext_val)
                  | (pad_oe_n & ~ext_en & churn_q);
endmodule

// ==== verification/shared_pin_function_mux_bench.sv ====
module shared_pin_function_mux_bench;
    timeunit 1ns;
    timeprecision 1ns;

    localparam pin_mux_pkg::fn_t    fg  = pin_mux_pkg::FN_GPIO;
    localparam pin_mux_pkg::fn_t    fp  = pin_mux_pkg::FN_PERIPH;
    localparam pin_mux_pkg::fn_t    fi  = pin_mux_pkg::FN_IRQ;
    localparam pin_mux_pkg::gmode_t gp  = pin_mux_pkg::GM_PLAIN;
    localparam pin_mux_pkg::gmode_t gi0 = pin_mux_pkg::GM_DED_IN0;
    localparam pin_mux_pkg::gmode_t gi1 = pin_mux_pkg::GM_DED_IN1;
    localparam pin_mux_pkg::gmode_t go0 = pin_mux_pkg::GM_DED_OUT0;
    localparam pin_mux_pkg::gmode_t go1 = pin_mux_pkg::GM_DED_OUT1;

    // cfg: dir, cnt drive, tsyn drive, rsyn as b, rclk as c, rclk drive
    // fl: core drive value, board value, expected oe_n, expected pad_out
    typedef struct {
        int                  pin;
        pin_mux_pkg::fn_t    fn;
        pin_mux_pkg::gmode_t gm;
        logic [5:0]          cfg;
        logic [3:0]          fl;
        logic [12:0]         vec;
    } row_t;

    logic                   mclk;
    logic                   sys_rst;
    pin_mux_pkg::fn_t       pin_fn [pin_mux_pkg::NUM_PINS];
    pin_mux_pkg::gmode_t    gpio_mode [pin_mux_pkg::NUM_PINS];
    logic                   counter_a_drive, counter_b_drive, tsyn_drive;
    logic                   rsyn_as_data_b, rclk_as_data_c, rclk_drive;
    logic [31:0]            gpio_out, gpio_dir, ded_out0, ded_out1;
    logic [31:0]            gpio_rd, ded_rd0, ded_rd1;
    logic                   counter_a_out, counter_b_out;
    logic                   counter_a_in, counter_b_in;
    logic                   tx_frame_sync_out, data_d_out;
    logic                   rx_clock_out, data_c_out;
    logic                   tx_frame_sync_in, tx_clock_in, rx_frame_sync_in;
    logic                   rx_clock_in, data_a_in, data_b_in, data_c_in;
    logic [14:0]            irq_req;
    logic                   power_on_reset_in;
    logic                   identity_strap_bit0, identity_strap_bit1;
    logic                   identity_strap_bit2;
    logic [2:0]             identity_id;
    logic [31:0]            pad_in, pad_out, pad_oe_n, ext_en, ext_val;
    int                     errors;
    int                     cmp_count;

    row_t rows [24] = '{
        '{0, fg, gp, 6'h00, 4'h6, 13'h1000},
        '{0, fg, gp, 6'h20, 4'h9, 13'h1000},
        '{9, fg, gi0, 6'h00, 4'h6, 13'h0800},
        '{9, fg, gi1, 6'h00, 4'h6, 13'h0400},
        '{9, fg, go0, 6'h00, 4'h9, 13'h0000},
        '{9, fg, go1, 6'h00, 4'h8, 13'h0000},
        '{1, fp, gp, 6'h00, 4'h6, 13'h0200},
        '{1, fp, gp, 6'h10, 4'h9, 13'h0000},
        '{2, fp, gp, 6'h00, 4'h6, 13'h0100},
        '{2, fp, gp, 6'h10, 4'h0, 13'h0000},
        '{3, fp, gp, 6'h00, 4'h6, 13'h0080},
        '{3, fp, gp, 6'h08, 4'h9, 13'h0000},
        '{4, fp, gp, 6'h3F, 4'hE, 13'h0040},
        '{5, fp, gp, 6'h00, 4'h9, 13'h0000},
        '{5, fp, gp, 6'h00, 4'h4, 13'h0000},
        '{6, fp, gp, 6'h00, 4'h6, 13'h0020},
        '{6, fp, gp, 6'h04, 4'h6, 13'h0004},
        '{7, fp, gp, 6'h00, 4'h6, 13'h0010},
        '{7, fp, gp, 6'h02, 4'h6, 13'h0002},
        '{7, fp, gp, 6'h01, 4'h9, 13'h0000},
        '{7, fp, gp, 6'h03, 4'h8, 13'h0000},
        '{8, fp, gp, 6'h00, 4'h6, 13'h0008},
        '{18, fi, gp, 6'h00, 4'h6, 13'h0000},
        '{0, fp, gp, 6'h00, 4'h6, 13'h0000}
    };

    shared_pin_function_mux u_shared_pin_function_mux (
        .mclk, .sys_rst, .pin_fn, .gpio_mode,
        .counter_a_drive, .counter_b_drive, .tsyn_drive,
        .rsyn_as_data_b, .rclk_as_data_c, .rclk_drive,
        .gpio_out, .gpio_dir, .ded_out0, .ded_out1,
        .gpio_rd, .ded_rd0, .ded_rd1,
        .counter_a_out, .counter_b_out, .counter_a_in, .counter_b_in,
        .tx_frame_sync_out, .data_d_out, .rx_clock_out, .data_c_out,
        .tx_frame_sync_in, .tx_clock_in, .rx_frame_sync_in, .rx_clock_in,
        .data_a_in, .data_b_in, .data_c_in, .irq_req,
        .power_on_reset_in, .identity_strap_bit0, .identity_strap_bit1,
        .identity_strap_bit2, .identity_id,
        .pad_in, .pad_out, .pad_oe_n
    );

    board_model u_board_model (
        .mclk, .pad_out, .pad_oe_n, .ext_en, .ext_val, .pad_in
    );

    always #50 mclk = ~mclk;

    task automatic check(input string name, input logic [31:0] got,
                         input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // one pin gets the row's function, every other pin falls back to
    // plain gpio input; only the row's pin is driven by the board
    task automatic apply(input row_t r);
        logic d;
        @(posedge mclk);
        d = r.fl[3];
        for (int i = 0; i < pin_mux_pkg::NUM_PINS; i++) begin
            pin_fn[i] <= (i == r.pin) ? r.fn : fg;
            gpio_mode[i] <= (i == r.pin) ? r.gm : gp;
        end
        gpio_dir <= {31'h0, r.cfg[5]} << r.pin;
        counter_a_drive <= r.cfg[4];
        counter_b_drive <= r.cfg[4];
        tsyn_drive <= r.cfg[3];
        rsyn_as_data_b <= r.cfg[2];
        rclk_as_data_c <= r.cfg[1];
        rclk_drive <= r.cfg[0];
        gpio_out <= {32{d}};
        ded_out0 <= {32{d}};
        ded_out1 <= {32{~d}};
        counter_a_out <= d;
        counter_b_out <= d;
        tx_frame_sync_out <= d;
        data_d_out <= d;
        rx_clock_out <= d;
        data_c_out <= ~d;
        ext_en <= 32'h1 << r.pin;
        ext_val <= {31'h0, r.fl[2]} << r.pin;
    endtask

    // pad feedback needs two register stages to reach a read port
    task automatic settle();
        repeat (3) @(posedge mclk);
        @(negedge mclk);
    endtask

    initial begin
        repeat (3000) @(posedge mclk);
        errors++;
        results();
    end

    initial begin
        int p;
        mclk = 1'h0;
        sys_rst = 1'h1;
        errors = 0;
        cmp_count = 0;
        power_on_reset_in = 1'h0;
        identity_strap_bit0 = 1'h1;
        identity_strap_bit1 = 1'h0;
        identity_strap_bit2 = 1'h1;
        apply(rows[0]);
        repeat (10) @(posedge mclk);
        sys_rst <= 1'h0;
        foreach (rows[n]) begin
            apply(rows[n]);
            settle();
            p = rows[n].pin;
            check("pad_oe_n", pad_oe_n, ~({31'h0, ~rows[n].fl[1]} << p));
            if (rows[n].fl[1] == 1'h0) begin
                check("pad_out", pad_out[p], rows[n].fl[0]);
            end
            check("core_in", {gpio_rd[p], ded_rd0[p], ded_rd1[p],
                counter_a_in, counter_b_in, tx_frame_sync_in, tx_clock_in,
                rx_frame_sync_in, rx_clock_in, data_a_in, data_b_in,
                data_c_in, |irq_req}, rows[n].vec);
        end
        // one-cycle answer: nothing before the sampling edge, data after
        apply(rows[0]);
        settle();
        apply(rows[13]);
        @(negedge mclk);
        check("oe_early", pad_oe_n[5], 1'h1);
        @(negedge mclk);
        check("oe_walk", pad_oe_n[5], 1'h0);
        check("out_walk", pad_out[5], 1'h1);
        for (int k = 0; k < pin_mux_pkg::NUM_IRQ; k++) begin
            apply('{k + 3, fi, gp, 6'h00, 4'h6, 13'h0001});
            settle();
            check("irq_req", irq_req, 15'h0001 << k);
        end
        // reset in mid-run releases every pad at once
        @(posedge mclk);
        sys_rst <= 1'h1;
        @(negedge mclk);
        check("rst_oe", pad_oe_n, 32'hFFFFFFFF);
        check("rst_irq", irq_req, 15'h0000);
        repeat (9) @(posedge mclk);
        sys_rst <= 1'h0;
        settle();
        check("id_idle", identity_id, 3'h0);
        @(posedge mclk);
        power_on_reset_in <= 1'h1;
        settle();
        check("id_cap", identity_id, 3'h5);
        @(posedge mclk);
        identity_strap_bit1 <= 1'h1;
        settle();
        check("id_hold", identity_id, 3'h5);
        @(posedge mclk);
        power_on_reset_in <= 1'h0;
        settle();
        @(posedge mclk);
        power_on_reset_in <= 1'h1;
        settle();
        check("id_recap", identity_id, 3'h7);
        results();
    end
endmodule
